//--- include/gpio_ports_defines.svh
`ifndef GPIO_PORTS_DEFINES_SVH
`define GPIO_PORTS_DEFINES_SVH
// ***************************************************
// register indices, byte address is four times index
// ***************************************************
`define LOW_PORT_DATA_IDX 10'h000
`define HIGH_PORT_DATA_IDX 10'h001
`define LOW_PORT_DIRECTION_IDX 10'h002
`define HIGH_PORT_CONTROL_IDX 10'h004
`define HIGH_PORT_FUNCTION_IDX 10'h005
// ***************************************************
// reset values
// ***************************************************
`define LOW_PORT_DATA_RST 8'h00
`define HIGH_PORT_DATA_RST 8'h00
`define LOW_PORT_DIRECTION_RST 8'h00
`define HIGH_PORT_CONTROL_RST 8'h00
`define HIGH_PORT_FUNCTION_RST 8'h00
`endif

//--- include/gpio_ports_pkg.sv
`default_nettype none
package gpio_ports_pkg;
   // ***************************************************
   // register select
   // ***************************************************
   typedef enum logic [2:0] {
      SEL_LOW_DATA,
      SEL_HIGH_DATA,
      SEL_LOW_DIR,
      SEL_HIGH_CTL,
      SEL_HIGH_FN,
      SEL_NONE
   } reg_sel_t;
   // ***************************************************
   // whole state of the block
   // ***************************************************
   typedef struct packed {
      logic [7:0] low_latch;
      logic [7:0] high_latch;
      logic [7:0] low_dir;
      logic [7:0] high_ctl;
      logic [7:0] high_fn;
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [15:0] sync3;
      logic [15:0] pin_filt;
      logic [7:0] low_out;
      logic [7:0] low_oe;
      logic [7:0] high_out;
      logic [7:0] high_oe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_t;
endpackage
`default_nettype wire

//--- rtl/gpio_ports_with_data_bus.sv
// Operation
// - low port pins each input or output
// - reset clears low direction, all inputs
// - memory write drives data 0-7, any memory access clears direction
// - high port pins may be data 8-15
// - reset clears high latch, control, function
//
// The APB slave port was left to the implementer.
`include "gpio_ports_defines.svh"
`default_nettype none
module gpio_ports_with_data_bus
   import gpio_ports_pkg::*;
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // external memory access from bus controller
   input wire logic MEM_ACCESS,
   input wire logic MEM_WRITE,
   input wire logic [15:0] MEM_WDATA,
   output logic [15:0] MEM_RDATA,
   // low byte pins
   input wire logic [7:0] LOW_PIN_IN,
   output logic [7:0] LOW_PIN_OUT,
   output logic [7:0] LOW_PIN_OE,
   // high byte pins
   input wire logic [7:0] HIGH_PIN_IN,
   output logic [7:0] HIGH_PIN_OUT,
   output logic [7:0] HIGH_PIN_OE
);
   // ***************************************************
   // address decode
   // ***************************************************
   function automatic reg_sel_t decode_addr(input logic [11:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         unique case (addr[11:2])
            `LOW_PORT_DATA_IDX: sel = SEL_LOW_DATA;
            `HIGH_PORT_DATA_IDX: sel = SEL_HIGH_DATA;
            `LOW_PORT_DIRECTION_IDX: sel = SEL_LOW_DIR;
            `HIGH_PORT_CONTROL_IDX: sel = SEL_HIGH_CTL;
            `HIGH_PORT_FUNCTION_IDX: sel = SEL_HIGH_FN;
            default: sel = SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   state_t r;
   state_t nxt;
   reg_sel_t sel;
   logic wr_done;
   logic acc_first;
   logic [7:0] low_rd_mix;
   logic [7:0] high_rd_mix;
   logic [7:0] high_out_mode;
   logic [7:0] high_bus_mode;

   assign sel = decode_addr(PADDR);
   assign acc_first = PSEL && PENABLE && !r.pready;
   assign wr_done = PSEL && PENABLE && r.pready && PWRITE;
   assign high_out_mode = ~r.high_fn & r.high_ctl;
   assign high_bus_mode = r.high_fn & ~r.high_ctl;

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      nxt = r;
      // three stage pin sampler, change taken when stages two and three agree
      nxt.sync1 = {HIGH_PIN_IN, LOW_PIN_IN};
      nxt.sync2 = r.sync1;
      nxt.sync3 = r.sync2;
      for (int i = 0; i < 16; i++) begin
         if (r.sync2[i] == r.sync3[i]) begin
            nxt.pin_filt[i] = r.sync3[i];
         end
      end
      // read view: latch for output pins, pin level otherwise
      low_rd_mix = (r.low_dir & r.low_latch) | (~r.low_dir & r.pin_filt[7:0]);
      high_rd_mix = (high_out_mode & r.high_latch) | (~high_out_mode & r.pin_filt[15:8]);
      // register writes, latch only
      if (wr_done) begin
         unique case (sel)
            SEL_LOW_DATA: nxt.low_latch = PWDATA[7:0];
            SEL_HIGH_DATA: nxt.high_latch = PWDATA[7:0];
            SEL_LOW_DIR: nxt.low_dir = PWDATA[7:0];
            SEL_HIGH_CTL: nxt.high_ctl = PWDATA[7:0];
            SEL_HIGH_FN: nxt.high_fn = PWDATA[7:0];
            SEL_NONE: nxt.low_dir = r.low_dir;
         endcase
      end
      // memory access owns the low direction register
      if (MEM_ACCESS) begin
         nxt.low_dir = 8'h00;
      end
      // apb answer, one wait cycle
      nxt.pready = acc_first;
      nxt.pslverr = 1'b0;
      if (acc_first) begin
         nxt.prdata = 32'h0000_0000;
         nxt.pslverr = (sel == SEL_NONE);
         if (!PWRITE) begin
            unique case (sel)
               SEL_LOW_DATA: nxt.prdata[7:0] = low_rd_mix;
               SEL_HIGH_DATA: nxt.prdata[7:0] = high_rd_mix;
               SEL_LOW_DIR, SEL_HIGH_CTL, SEL_HIGH_FN, SEL_NONE: nxt.prdata = 32'h0000_0000;
            endcase
         end
      end
      // low pins
      if (MEM_ACCESS) begin
         nxt.low_oe = {8{MEM_WRITE}};
         nxt.low_out = MEM_WDATA[7:0];
      end else begin
         nxt.low_oe = r.low_dir;
         nxt.low_out = r.low_latch;
      end
      // high pins; function and control both set leaves the pin undriven
      for (int i = 0; i < 8; i++) begin
         if (high_bus_mode[i]) begin
            nxt.high_oe[i] = MEM_ACCESS && MEM_WRITE;
            nxt.high_out[i] = MEM_WDATA[8 + i];
         end else begin
            nxt.high_oe[i] = high_out_mode[i];
            nxt.high_out[i] = r.high_latch[i];
         end
      end
   end

   // ***************************************************
   // state register
   // ***************************************************
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         r <= '0;
         r.low_latch <= `LOW_PORT_DATA_RST;
         r.high_latch <= `HIGH_PORT_DATA_RST;
         r.low_dir <= `LOW_PORT_DIRECTION_RST;
         r.high_ctl <= `HIGH_PORT_CONTROL_RST;
         r.high_fn <= `HIGH_PORT_FUNCTION_RST;
      end else begin
         r <= nxt;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign PRDATA = r.prdata;
   assign PREADY = r.pready;
   assign PSLVERR = r.pslverr;
   assign MEM_RDATA = r.pin_filt;
   assign LOW_PIN_OUT = r.low_out;
   assign LOW_PIN_OE = r.low_oe;
   assign HIGH_PIN_OUT = r.high_out;
   assign HIGH_PIN_OE = r.high_oe;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!ARST_N);

   // ***************************************************
   // assertion helpers
   // ***************************************************
   logic [7:0] mem_wlow;
   logic [7:0] mem_whigh;
   logic [7:0] wdata_byte;
   logic [7:0] high_role_oe;
   logic [7:0] high_both_set;

   assign mem_wlow = MEM_WDATA[7:0];
   assign mem_whigh = MEM_WDATA[15:8];
   assign wdata_byte = PWDATA[7:0];
   assign high_role_oe = high_out_mode | (high_bus_mode & {8{MEM_ACCESS && MEM_WRITE}});
   assign high_both_set = r.high_fn & r.high_ctl;

   sequence s_acc_start;
      PSEL && PENABLE && !PREADY;
   endsequence

   sequence s_answer;
      PREADY ##1 !PREADY;
   endsequence

   sequence s_mem_write;
      MEM_ACCESS && MEM_WRITE;
   endsequence

   sequence s_mem_read;
      MEM_ACCESS && !MEM_WRITE;
   endsequence

   sequence s_read_low;
      s_acc_start ##0 (!PWRITE && sel == SEL_LOW_DATA);
   endsequence

   sequence s_read_high;
      s_acc_start ##0 (!PWRITE && sel == SEL_HIGH_DATA);
   endsequence

   sequence s_read_wo;
      s_acc_start ##0
         (!PWRITE && (sel == SEL_LOW_DIR || sel == SEL_HIGH_CTL || sel == SEL_HIGH_FN));
   endsequence

   sequence s_write_low;
      wr_done && sel == SEL_LOW_DATA;
   endsequence

   sequence s_write_dir;
      wr_done && sel == SEL_LOW_DIR && !MEM_ACCESS;
   endsequence

   sequence s_err_write;
      wr_done && sel == SEL_NONE;
   endsequence

   property p_reset_values;
      @(posedge CORE_CLK) disable iff (1'b0)
      !ARST_N |-> (r.low_dir == 8'h00) && (r.high_ctl == 8'h00) &&
         (r.high_fn == 8'h00) && (r.high_latch == 8'h00) &&
         (LOW_PIN_OE == 8'h00) && (HIGH_PIN_OE == 8'h00);
   endproperty

   AST_RESET_INPUTS: assert property (p_reset_values)
      else $error("reset left a port register or pin enable set");

   AST_ONE_WAIT: assert property (s_acc_start |=> s_answer)
      else $error("apb answer not after exactly one wait cycle");

   AST_LOW_DIR_OE: assert property (!MEM_ACCESS |=> LOW_PIN_OE == $past(r.low_dir))
      else $error("low pin enable does not follow direction");

   AST_MEM_CLEARS_DIR: assert property (MEM_ACCESS |=> r.low_dir == 8'h00)
      else $error("memory access did not clear low direction");

   AST_MEM_LOW_DRIVE: assert property (s_mem_write |=>
      (LOW_PIN_OE == 8'hFF) && (LOW_PIN_OUT == $past(mem_wlow)))
      else $error("low pins not driving write data during memory access");

   AST_HIGH_BUS_DRIVE: assert property (s_mem_write |=>
      ((HIGH_PIN_OUT ^ $past(mem_whigh)) & $past(high_bus_mode)) == 8'h00)
      else $error("high bus pin not carrying write data");

   AST_HIGH_ROLE: assert property (1'b1 |=> HIGH_PIN_OE ==
      $past(high_role_oe))
      else $error("high pin enable does not match its role");

   AST_PROHIBITED_UNDRIVEN: assert property (1'b1 |=>
      (HIGH_PIN_OE & $past(high_both_set)) == 8'h00)
      else $error("pin with function and control set is driven");

   AST_WRITE_LATCH: assert property (wr_done && sel == SEL_HIGH_DATA |=>
      r.high_latch == $past(wdata_byte) && $stable(r.high_ctl) && $stable(r.high_fn))
      else $error("high data write did not land in latch only");

   AST_READ_MIX: assert property (s_read_low |=>
      PREADY && PRDATA == {24'h00_0000, $past(low_rd_mix)})
      else $error("low data read did not mix latch and pins");

   AST_READ_MIX_HIGH: assert property (s_read_high |=>
      PREADY && PRDATA == {24'h00_0000, $past(high_rd_mix)})
      else $error("high data read did not mix latch and pins");

   AST_WRITE_LATCH_LOW: assert property (s_write_low |=>
      r.low_latch == $past(wdata_byte))
      else $error("low data write did not land in latch");

   AST_LOW_DIR_WRITE: assert property (s_write_dir |=>
      r.low_dir == $past(wdata_byte))
      else $error("low direction write did not land");

   AST_LOW_OUT_LATCH: assert property (!MEM_ACCESS |=>
      LOW_PIN_OUT == $past(r.low_latch))
      else $error("low pin drive value does not follow latch");

   AST_MEM_READ_RELEASE: assert property (s_mem_read |=> LOW_PIN_OE == 8'h00)
      else $error("low pins driven during memory read");

   AST_HIGH_LATCH_DRIVE: assert property (1'b1 |=>
      ((HIGH_PIN_OUT ^ $past(r.high_latch)) & $past(high_out_mode)) == 8'h00)
      else $error("high output pin not carrying its latch");

   AST_UNMAPPED_ERR: assert property (s_acc_start ##0 (sel == SEL_NONE) |=>
      PREADY && PSLVERR)
      else $error("unmapped access not answered with an error");

   AST_MAPPED_OK: assert property (s_acc_start ##0 (sel != SEL_NONE) |=>
      PREADY && !PSLVERR)
      else $error("mapped access answered with an error");

   AST_ERR_WRITE_IGNORED: assert property (s_err_write |=>
      $stable(r.low_latch) && $stable(r.high_latch) && $stable(r.high_ctl) && $stable(r.high_fn))
      else $error("refused write changed a register");

   AST_WO_READ_ZERO: assert property (s_read_wo |=> PRDATA == 32'h0000_0000)
      else $error("write-only register read not zero");

   AST_READY_PULSE: assert property (PREADY |=> !PREADY)
      else $error("ready held longer than one cycle");
endmodule
`default_nettype wire

//--- verification/pin_model.sv
`default_nettype none
module pin_model (
   // design side
   input wire logic [7:0] drive,
   input wire logic [7:0] drive_en,
   // far side
   input wire logic [7:0] ext,
   output logic [7:0] level
);
   timeunit 1ns;
   timeprecision 100ps;
   // undriven bits follow the far side
   always_comb level = (drive & drive_en) | (ext & ~drive_en);
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`include "gpio_ports_defines.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, arst_n, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic mem_access = 0, mem_write = 0;
   logic [15:0] mem_wdata = '0, mem_rdata;
   logic [7:0] lo_in, lo_out, lo_oe, hi_in, hi_out, hi_oe;
   logic [7:0] lo_ext = 8'h3C, hi_ext = 8'h96;
   int num_errors = 0, checks = 0;
   always #12.5 clk = ~clk;
   gpio_ports_with_data_bus dut (.CORE_CLK(clk), .ARST_N(arst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .MEM_ACCESS(mem_access), .MEM_WRITE(mem_write),
      .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .LOW_PIN_IN(lo_in),
      .LOW_PIN_OUT(lo_out), .LOW_PIN_OE(lo_oe), .HIGH_PIN_IN(hi_in),
      .HIGH_PIN_OUT(hi_out), .HIGH_PIN_OE(hi_oe));
   pin_model lo_pins (.drive(lo_out), .drive_en(lo_oe), .ext(lo_ext), .level(lo_in));
   pin_model hi_pins (.drive(hi_out), .drive_en(hi_oe), .ext(hi_ext), .level(hi_in));
   task automatic conclude;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) chk(n, 0);
   endtask
   task automatic t_reset;
      chk({lo_oe, hi_oe, hi_out}, 0);
      apb(0, {`LOW_PORT_DIRECTION_IDX, 2'b00}, 0);
      chk(rd, 0);
      apb(1, {`HIGH_PORT_CONTROL_IDX, 2'b00}, 1);
      apb(0, {`HIGH_PORT_DATA_IDX, 2'b00}, 0);
      chk(rd, 32'h0000_0096);
   endtask
   task automatic t_low;
      apb(1, {`LOW_PORT_DIRECTION_IDX, 2'b00}, 32'h0000_000F);
      apb(1, {`LOW_PORT_DATA_IDX, 2'b00}, 32'h0000_00A5);
      cyc(2);
      chk({lo_oe, lo_out & 8'h0F}, 16'h0F05);
      cyc(4);
      apb(0, {`LOW_PORT_DATA_IDX, 2'b00}, 0);
      chk(rd, 32'h0000_0035);
   endtask
   task automatic t_high;
      // function and control never both set in one bit
      apb(1, {`HIGH_PORT_DATA_IDX, 2'b00}, 32'h0000_000A);
      apb(1, {`HIGH_PORT_CONTROL_IDX, 2'b00}, 32'h0000_000F);
      apb(1, {`HIGH_PORT_FUNCTION_IDX, 2'b00}, 32'h0000_00F0);
      cyc(5);
      chk(hi_oe, 8'h0F);
      apb(0, {`HIGH_PORT_DATA_IDX, 2'b00}, 0);
      chk(rd, 32'h0000_009A);
   endtask
   task automatic t_mem;
      mem_access <= 1'b1;
      mem_write <= 1'b1;
      mem_wdata <= 16'h5AC3;
      cyc(2);
      chk({lo_oe, lo_out, hi_oe, hi_out}, 32'hFFC3_FF5A);
      mem_write <= 1'b0;
      cyc(6);
      chk({lo_oe, hi_oe, mem_rdata}, 32'h000F_9A3C);
      mem_access <= 1'b0;
      cyc(2);
      chk(lo_oe, 0);
      apb(0, {`LOW_PORT_DIRECTION_IDX, 2'b00}, 0);
      chk(lo_oe, 0);
   endtask
   task automatic t_err;
      apb(0, 12'h00C, 0);
      chk(err, 1);
      chk(rd, 0);
      apb(1, 12'h00A, 32'h0000_00FF);
      cyc(2);
      chk({err, lo_oe}, 9'h100);
   endtask
   task automatic t_rst2;
      apb(1, {`LOW_PORT_DIRECTION_IDX, 2'b00}, 32'h0000_00FF);
      cyc(2);
      chk(lo_oe, 8'hFF);
      arst_n <= 1'b0;
      cyc(2);
      chk({lo_oe, hi_oe, hi_out}, 0);
      arst_n <= 1'b1;
      cyc(6);
      apb(0, {`HIGH_PORT_DATA_IDX, 2'b00}, 0);
      chk(rd, 32'h0000_0096);
      apb(1, {`HIGH_PORT_CONTROL_IDX, 2'b00}, 32'h0000_00FF);
      apb(0, {`HIGH_PORT_DATA_IDX, 2'b00}, 0);
      chk(rd, 0);
   endtask
   initial begin
      arst_n <= 1'b0;
      cyc(8);
      arst_n <= 1'b1;
      t_reset();
      t_low();
      t_high();
      t_mem();
      t_err();
      t_rst2();
      conclude();
   end
   initial begin
      #50000;
      num_errors++;
      conclude();
   end
endmodule
`default_nettype wire
